// File: hdl/intc_command_reg.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Sixteen-bit command, all zero after reset
// - Bit 8 enables parity error messages
// - Capability error bits ignore bit 8
// - Bit 6 gates write parity reporting
// - Bit 2 gates upstream memory and I/O requests
// - Completions flow regardless of bit 2
// - Only memory and I/O requests gated
// - Bit 1 clear master-aborts memory accesses
// - Bits 5, 4, 3 read zero
// - Bits 15:9, 7, 0 reserved zero
// - Sent error message sets status bit 14
module intc_command_reg
    import cmd_reg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic cfg_wr_poisoned,
    output logic [31:0] cfg_rdata,
    output logic cfg_rd_valid,
    input wire logic tgt_req_valid,
    input wire logic tgt_req_write,
    input wire logic tgt_req_poisoned,
    output logic tgt_req_accept,
    output logic tgt_req_abort,
    input wire logic up_req_valid,
    input wire logic [1:0] up_req_type,
    output logic up_req_grant,
    output logic up_req_blocked,
    input wire logic cpl_valid,
    output logic cpl_grant,
    input wire logic err_severity_fatal,
    input wire logic err_msg_ready,
    output logic err_msg_valid,
    output logic err_msg_fatal,
    output logic cap_err_detected,
    output logic cap_err_fatal,
    output logic memory_decode_enable,
    output logic master_request_enable,
    output logic parity_check_enable,
    output logic error_message_enable
);

    // ==========================================
    // Address decode
    // ==========================================
    // Command and status share one dword
    wire [5:0] cmd_dword = CMD_OFFSET[7:2];
    wire [5:0] sts_dword = STATUS_OFFSET[7:2];
    wire [5:0] acc_dword = cfg_addr[7:2];
    // Access falls on the command dword
    wire cmd_hit = (acc_dword == cmd_dword);
    // Access falls on the status dword
    wire sts_hit = (acc_dword == sts_dword);
    // Qualified strobes
    wire cmd_wr = cfg_wr & cmd_hit;
    wire sts_wr = cfg_wr & sts_hit;
    wire any_rd = cfg_rd & (cmd_hit | sts_hit);

    // ==========================================
    // Command register bank
    // ==========================================
    logic [15:0] cmd_value; // Current command value

    // Only bits 8, 6, 2, 1 take writes
    cmd_bit_bank #(
        .WRITABLE(CMD_WRITABLE),
        .RESET_VALUE(CMD_RESET)
    ) u_cmd_bank (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(cmd_wr),
        .wr_be(cfg_be[1:0]),
        .wr_data(cfg_wdata[15:0]),
        .value(cmd_value)
    );

    // ==========================================
    // Named command fields
    // ==========================================
    // Memory target decode enable
    wire mem_dec = cmd_value[MEM_DECODE_BIT];
    // Upstream mastering enable
    wire mst_en = cmd_value[MASTER_REQ_BIT];
    // Write data parity checking
    wire par_en = cmd_value[PARITY_CHECK_BIT];
    // Error message enable
    wire msg_en = cmd_value[ERR_MSG_BIT];

    // Fixed-zero legacy fields, read back as stored
    wire io_decode = cmd_value[IO_DECODE_BIT];
    wire wait_cycle = cmd_value[WAIT_CYCLE_BIT];
    wire palette_snoop = cmd_value[PALETTE_SNOOP_BIT];
    wire special_cycle = cmd_value[SPECIAL_CYCLE_BIT];
    wire write_invalidate = cmd_value[WRITE_INVALIDATE_BIT];

    // Assembled read image; fixed fields are constant zero
    wire [15:0] cmd_image = {
        cmd_value[15:9],
        msg_en,
        wait_cycle,
        par_en,
        palette_snoop,
        write_invalidate,
        special_cycle,
        mst_en,
        mem_dec,
        io_decode
    };

    // Control levels to the rest of the function
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            memory_decode_enable <= 1'b0;
            master_request_enable <= 1'b0;
            parity_check_enable <= 1'b0;
            error_message_enable <= 1'b0;
        end else begin
            memory_decode_enable <= mem_dec;
            master_request_enable <= mst_en;
            parity_check_enable <= par_en;
            error_message_enable <= msg_en;
        end
    end

    // ==========================================
    // Memory target path
    // ==========================================
    // Accept only while decode is enabled
    assign tgt_req_accept = tgt_req_valid & mem_dec;
    // Otherwise the access is master aborted
    assign tgt_req_abort = tgt_req_valid & ~mem_dec;

    // ==========================================
    // Upstream request path
    // ==========================================
    // Memory and I/O requests are the gated kinds
    wire up_is_mem = (up_req_type == REQ_MEM);
    wire up_is_io = (up_req_type == REQ_IO);
    wire up_gated = up_is_mem | up_is_io;
    // Grant when mastering allowed or kind is ungated
    wire up_allow = mst_en | ~up_gated;
    assign up_req_grant = up_req_valid & up_allow;
    // Held off while mastering disabled
    assign up_req_blocked = up_req_valid & ~up_allow;

    // Completions never depend on the master enable
    assign cpl_grant = cpl_valid;

    // ==========================================
    // Parity error detection
    // ==========================================
    // Poisoned write data to accepted memory writes
    wire mem_par_err = tgt_req_accept & tgt_req_write
                       & tgt_req_poisoned;
    // Poisoned write data to the command/status dword
    wire cfg_par_err = cfg_wr & (cmd_hit | sts_hit) & cfg_wr_poisoned;
    // Checked only while parity checking is on
    wire par_event = par_en & (mem_par_err | cfg_par_err);
    // Message requested only while messages enabled
    wire msg_event = par_event & msg_en;

    // Capability error bits follow every checked error
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cap_err_detected <= 1'b0;
            cap_err_fatal <= 1'b0;
        end else begin
            cap_err_detected <= par_event;
            cap_err_fatal <= par_event & err_severity_fatal;
        end
    end

    // ==========================================
    // Error message sender
    // ==========================================
    logic msg_sent; // Pulse: link took a message

    err_msg_sender u_err_sender (
        .clk_sys(clk_sys),
        .reset(reset),
        .err_event(msg_event),
        .err_fatal(err_severity_fatal),
        .msg_ready(err_msg_ready),
        .msg_valid(err_msg_valid),
        .msg_fatal(err_msg_fatal),
        .msg_sent(msg_sent)
    );

    // ==========================================
    // Status flag
    // ==========================================
    logic sse_reg; // Signaled system error flag
    logic sse_next;

    // Write one to bit 14 of the status half clears it
    wire sse_clr = sts_wr & cfg_be[3]
                   & cfg_wdata[STATUS_LANE_SHIFT + SSE_FLAG_BIT];

    // Set wins over a clear in the same cycle
    always_comb begin
        sse_next = sse_reg;
        if (msg_sent) begin
            sse_next = 1'b1;
        end else if (sse_clr) begin
            sse_next = 1'b0;
        end
    end

    // Flag storage
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sse_reg <= SSE_RESET;
        end else begin
            sse_reg <= sse_next;
        end
    end

    // Status image: fixed bits plus the flag
    wire [15:0] sts_image = STATUS_FIXED
                            | (16'(sse_reg) << SSE_FLAG_BIT);

    // ==========================================
    // Read data
    // ==========================================
    // Unmapped dwords read as zero
    wire [31:0] rd_word = any_rd ? {sts_image, cmd_image} : 32'h0000_0000;

    // Read data and its strobe, one cycle after the read
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_rd_valid <= 1'b0;
        end else begin
            cfg_rd_valid <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata <= rd_word;
            end
        end
    end

endmodule

`default_nettype wire

// File: shared/cmd_reg_pkg.sv
`default_nettype none

package cmd_reg_pkg;

    // ==========================================
    // Configuration access geometry
    // ==========================================
    localparam int CFG_ADDR_W = 8;
    localparam logic [7:0] CMD_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h06;
    localparam int STATUS_LANE_SHIFT = 16;

    // ==========================================
    // Command register layout
    // ==========================================
    localparam int CMD_W = 16;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [15:0] CMD_WRITABLE = 16'h0146;
    localparam int IO_DECODE_BIT = 0;
    localparam int MEM_DECODE_BIT = 1;
    localparam int MASTER_REQ_BIT = 2;
    localparam int SPECIAL_CYCLE_BIT = 3;
    localparam int WRITE_INVALIDATE_BIT = 4;
    localparam int PALETTE_SNOOP_BIT = 5;
    localparam int PARITY_CHECK_BIT = 6;
    localparam int WAIT_CYCLE_BIT = 7;
    localparam int ERR_MSG_BIT = 8;

    // ==========================================
    // Status register layout
    // ==========================================
    localparam int SSE_FLAG_BIT = 14;
    localparam logic [15:0] STATUS_FIXED = 16'h0010;
    localparam logic SSE_RESET = 1'b0;

    // ==========================================
    // Request kinds heading upstream
    // ==========================================
    typedef enum logic [1:0] {
        REQ_MEM = 2'h0,
        REQ_IO = 2'h1,
        REQ_CFG = 2'h2,
        REQ_MSG = 2'h3
    } req_type_t;

    // ==========================================
    // Error message sender states
    // ==========================================
    typedef enum logic [1:0] {
        ERR_IDLE = 2'h0,
        ERR_SEND = 2'h1,
        ERR_GAP = 2'h3
    } err_state_t;

endpackage

`default_nettype wire

// File: hdl/cmd_bit_bank.sv
`timescale 1ns/1ps
`default_nettype none

// Byte-lane writable bank; fixed bits stay at their reset value
module cmd_bit_bank
    import cmd_reg_pkg::*;
#(
    parameter logic [15:0] WRITABLE = CMD_WRITABLE,
    parameter logic [15:0] RESET_VALUE = CMD_RESET
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [1:0] wr_be,
    input wire logic [15:0] wr_data,
    output logic [15:0] value
);

    // ==========================================
    // One cell per bit
    // ==========================================
    genvar i;
    generate
        for (i = 0; i < CMD_W; i++) begin : g_bit
            if (WRITABLE[i]) begin : g_rw
                // Lane strobe for this bit
                wire lane_hit = wr_en & wr_be[i / 8];
                logic bit_reg;
                // Cleared by reset, loaded on a strobed write
                always_ff @(posedge clk_sys or posedge reset) begin
                    if (reset) begin
                        bit_reg <= RESET_VALUE[i];
                    end else if (lane_hit) begin
                        bit_reg <= wr_data[i];
                    end
                end
                assign value[i] = bit_reg;
            end else begin : g_ro
                // Hardwired; writes have no effect
                assign value[i] = RESET_VALUE[i];
            end
        end
    endgenerate

endmodule

`default_nettype wire

// File: hdl/err_msg_sender.sv
`timescale 1ns/1ps
`default_nettype none

// Queues fatal / non-fatal error messages toward the link
module err_msg_sender
    import cmd_reg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic err_event,
    input wire logic err_fatal,
    input wire logic msg_ready,
    output logic msg_valid,
    output logic msg_fatal,
    output logic msg_sent
);

    // ==========================================
    // State and pending flags
    // ==========================================
    err_state_t state_reg, state_next;
    logic fatal_pend_reg; // Fatal message waiting
    logic nonfatal_pend_reg; // Non-fatal message waiting
    logic kind_reg; // Kind of message in flight

    // Handshake completion
    assign msg_valid = (state_reg == ERR_SEND);
    assign msg_sent = msg_valid & msg_ready;
    assign msg_fatal = kind_reg;

    // New events; set wins over the clear on send
    wire set_fatal = err_event & err_fatal;
    wire set_nonfatal = err_event & ~err_fatal;
    wire clr_fatal = msg_sent & kind_reg;
    wire clr_nonfatal = msg_sent & ~kind_reg;
    wire any_pend = fatal_pend_reg | nonfatal_pend_reg;

    // ==========================================
    // Next state
    // ==========================================
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ERR_IDLE: begin
                // Start when something waits
                if (any_pend) begin
                    state_next = ERR_SEND;
                end
            end
            ERR_SEND: begin
                // Hold until the link takes it
                if (msg_ready) begin
                    state_next = ERR_GAP;
                end
            end
            ERR_GAP: begin
                // One gap cycle, then IDLE: two idle cycles between messages
                state_next = ERR_IDLE;
            end
            default: begin
                state_next = ERR_IDLE;
            end
        endcase
    end

    // ==========================================
    // Registers
    // ==========================================
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg <= ERR_IDLE;
            fatal_pend_reg <= 1'b0;
            nonfatal_pend_reg <= 1'b0;
            kind_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            fatal_pend_reg <= (fatal_pend_reg & ~clr_fatal) | set_fatal;
            nonfatal_pend_reg <= (nonfatal_pend_reg & ~clr_nonfatal)
                                 | set_nonfatal;
            // Fatal goes first when both wait
            if (state_reg == ERR_IDLE && any_pend) begin
                kind_reg <= fatal_pend_reg;
            end
        end
    end

endmodule

`default_nettype wire

// File: testbench/intc_command_reg_checker.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Port-level checker for the command register
// ==========================================
module intc_command_reg_checker (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rd_valid,
    input wire logic tgt_req_valid,
    input wire logic tgt_req_accept,
    input wire logic tgt_req_abort,
    input wire logic up_req_valid,
    input wire logic [1:0] up_req_type,
    input wire logic up_req_grant,
    input wire logic up_req_blocked,
    input wire logic cpl_valid,
    input wire logic cpl_grant,
    input wire logic err_msg_ready,
    input wire logic err_msg_valid,
    input wire logic err_msg_fatal,
    input wire logic cap_err_detected,
    input wire logic memory_decode_enable,
    input wire logic master_request_enable,
    input wire logic parity_check_enable,
    input wire logic error_message_enable
);
    // Single clock domain, reset disables all
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // All enables start cleared
    AST_RESET_CLEAR: assert property (
        $fell(reset) |-> !memory_decode_enable && !master_request_enable
            && !parity_check_enable && !error_message_enable)
        else $error("enable set after reset");
    // Accept follows the memory decode bit
    AST_TGT_ACCEPT: assert property (
        tgt_req_valid |=> memory_decode_enable == $past(tgt_req_accept))
        else $error("accept not tied to decode bit");
    // Abort is the opposite answer
    AST_TGT_ABORT: assert property (
        tgt_req_valid |=> memory_decode_enable != $past(tgt_req_abort))
        else $error("abort not tied to decode bit");
    // Memory and I/O requests gated by mastering bit
    AST_UP_GATED: assert property (
        up_req_valid && !up_req_type[1]
            |=> master_request_enable == $past(up_req_grant))
        else $error("grant not tied to master bit");
    // Other request kinds always pass
    AST_UP_OTHER: assert property (
        up_req_valid && up_req_type[1] |-> up_req_grant && !up_req_blocked)
        else $error("config or message request blocked");
    // Completions never held back
    AST_CPL_FREE: assert property (
        cpl_grant == cpl_valid)
        else $error("completion held back");
    // Fixed command bits read zero
    AST_CMD_FIXED: assert property (
        cfg_rd_valid && $past(cfg_addr[7:2]) == 6'h01
            |-> (cfg_rdata[15:0] & 16'hfeb9) == 16'h0000)
        else $error("fixed command bit reads one");
    // Enabled error leads to a message soon
    AST_MSG_RAISED: assert property (
        cap_err_detected && error_message_enable |-> ##[0:4] err_msg_valid)
        else $error("no error message raised");
    // Message holds until taken
    AST_MSG_HOLD: assert property (
        err_msg_valid && !err_msg_ready
            |=> err_msg_valid && $stable(err_msg_fatal))
        else $error("error message dropped");

    // Main scenarios seen
    cover property (tgt_req_accept);
    cover property (err_msg_valid && err_msg_ready);
    cover property (cfg_rd_valid && cfg_rdata[30]);
endmodule

bind intc_command_reg intc_command_reg_checker chk (.clk_sys, .reset,
    .cfg_addr, .cfg_rdata, .cfg_rd_valid, .tgt_req_valid, .tgt_req_accept,
    .tgt_req_abort, .up_req_valid, .up_req_type, .up_req_grant,
    .up_req_blocked, .cpl_valid, .cpl_grant, .err_msg_ready, .err_msg_valid,
    .err_msg_fatal, .cap_err_detected, .memory_decode_enable,
    .master_request_enable, .parity_check_enable, .error_message_enable);

`default_nettype wire

// File: testbench/msg_sink_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Upstream sink for error messages
// ==========================================
module msg_sink_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic slow,
    input wire logic err_msg_valid,
    input wire logic err_msg_fatal,
    output logic err_msg_ready,
    output logic [7:0] msg_count,
    output logic last_fatal
);
    logic [1:0] wait_reg;  // Cycles a message has waited

    // Slow mode holds off three cycles
    assign err_msg_ready = err_msg_valid & (~slow | (wait_reg == 2'h3));

    // Count taken messages and note severity
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wait_reg <= 2'h0;
            msg_count <= 8'h00;
            last_fatal <= 1'b0;
        end else if (err_msg_ready) begin
            wait_reg <= 2'h0;
            msg_count <= msg_count + 8'h01;
            last_fatal <= err_msg_fatal;
        end else if (err_msg_valid) begin
            wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule

`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Self-checking bench for the command register
// ==========================================
module tb_top
    import cmd_reg_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic cfg_wr_poisoned = 1'b0;  // Write data marked bad
    logic tgt_req_valid = 1'b0;
    logic tgt_req_write = 1'b0;
    logic tgt_req_poisoned = 1'b0;
    logic up_req_valid = 1'b0;
    logic [1:0] up_req_type = 2'h0;
    logic cpl_valid = 1'b0;
    logic err_severity_fatal = 1'b0;
    logic slow = 1'b0;
    wire logic [31:0] cfg_rdata;
    wire logic cfg_rd_valid, tgt_req_accept, tgt_req_abort, up_req_grant;
    wire logic up_req_blocked, cpl_grant, err_msg_ready, err_msg_valid;
    wire logic err_msg_fatal, cap_err_detected, last_fatal, cap_err_fatal;
    wire logic memory_decode_enable, master_request_enable;
    wire logic parity_check_enable, error_message_enable;
    wire logic [7:0] msg_count;
    int bad_count = 0;
    int n_checks = 0;
    int cap_n = 0;  // Capability error pulses seen
    logic [31:0] exp_q[$];  // Expected read data, oldest first
    logic [31:0] rnd = 32'h9974;
    logic [15:0] cmd_m = 16'h0000;  // Expected command value
    logic [15:0] pcase[3] = '{16'h0042, 16'h0142, 16'h0102};

    intc_command_reg dut (.clk_sys, .reset, .cfg_wr, .cfg_rd, .cfg_addr,
        .cfg_be, .cfg_wdata, .cfg_wr_poisoned, .cfg_rdata,
        .cfg_rd_valid, .tgt_req_valid, .tgt_req_write, .tgt_req_poisoned,
        .tgt_req_accept, .tgt_req_abort, .up_req_valid, .up_req_type,
        .up_req_grant, .up_req_blocked, .cpl_valid, .cpl_grant,
        .err_severity_fatal, .err_msg_ready, .err_msg_valid, .err_msg_fatal,
        .cap_err_detected, .cap_err_fatal, .memory_decode_enable,
        .master_request_enable, .parity_check_enable, .error_message_enable);
    msg_sink_model sink (.clk_sys, .reset, .slow, .err_msg_valid,
        .err_msg_fatal, .err_msg_ready, .msg_count, .last_fatal);

    // ==========================================
    // Clock, helpers
    // ==========================================
    always #12.5 clk_sys = ~clk_sys;

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Expected dword 1 with given error flag
    function automatic logic [31:0] stat(input logic signaled_system_error_flag);
        return {STATUS_FIXED | {1'b0, signaled_system_error_flag, 14'h0}, cmd_m};
    endfunction

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One config access, then an idle cycle
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [3:0] be, input logic [31:0] d);
        cfg_wr <= w;
        cfg_rd <= ~w;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Command write, expected value keeps only writable bits
    task automatic wr_cmd(input logic [1:0] be, input logic [15:0] d);
        acc(1'b1, 8'h04, {2'b00, be}, {16'h0000, d});
        if (be[0]) cmd_m[7:0] = d[7:0] & CMD_WRITABLE[7:0];
        if (be[1]) cmd_m[15:8] = d[15:8] & CMD_WRITABLE[15:8];
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        acc(1'b0, a, 4'hf, 32'h0);
    endtask

    // ==========================================
    // Monitors
    // ==========================================
    always @(posedge clk_sys) begin
        if (cfg_rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected read", cfg_rdata, 32'hx);
            end else begin
                check("cfg_rdata", cfg_rdata, exp_q.pop_front());
            end
        end
        // Severity bit travels with each capability error pulse
        if (cap_err_detected === 1'b1) begin
            cap_n++;
            check("cap_fatal", 32'(cap_err_fatal),
                32'(err_severity_fatal));
        end
    end

    initial begin
        repeat (4000) @(posedge clk_sys);
        bad_count++;
        $display("watchdog expired");
        test_done();
    end

    // ==========================================
    // Tests
    // ==========================================
    initial begin
        int n0;
        int m0;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd_exp(8'h04, stat(1'b0));
        check("enables", 32'({memory_decode_enable, master_request_enable,
            parity_check_enable, error_message_enable}), 32'h0);
        $display("reset test done");
        // Fixed bits ignore writes, random lanes
        wr_cmd(2'b11, 16'hffff);
        rd_exp(8'h04, stat(1'b0));
        check("enables", 32'({memory_decode_enable, master_request_enable,
            parity_check_enable, error_message_enable}), 32'hf);
        repeat (8) begin
            rnd = xorshift(rnd);
            wr_cmd(rnd[17:16], rnd[15:0]);
            rd_exp(8'h04, stat(1'b0));
        end
        acc(1'b1, 8'h08, 4'hf, rnd);
        rd_exp(8'h08, 32'h0);
        $display("register test done");
        // Target and upstream gating, every request kind
        for (int k = 0; k < 2; k++) begin
            wr_cmd(2'b11, k ? 16'h0006 : 16'h0000);
            for (int t = 0; t < 4; t++) begin
                tgt_req_valid <= 1'b1;
                up_req_valid <= 1'b1;
                cpl_valid <= 1'b1;
                up_req_type <= 2'(t);
                @(posedge clk_sys);
                check("target", 32'({tgt_req_accept, tgt_req_abort}),
                    k ? 32'h2 : 32'h1);
                check("upstream", 32'({up_req_grant, up_req_blocked}),
                    (k || t > 1) ? 32'h2 : 32'h1);
                check("cpl_grant", 32'(cpl_grant), 32'h1);
            end
            tgt_req_valid <= 1'b0;
            up_req_valid <= 1'b0;
            cpl_valid <= 1'b0;
        end
        $display("gating test done");
        // Poisoned memory write, then poisoned config write, each mix
        for (int p = 0; p < 2; p++) begin
            foreach (pcase[i]) begin
                wr_cmd(2'b11, pcase[i]);
                rnd = xorshift(rnd);
                // Second pass always makes the sink hold off
                slow <= rnd[0] | (p == 1);
                err_severity_fatal <= rnd[1];
                n0 = cap_n;
                m0 = msg_count;
                if (p == 0) begin
                    tgt_req_valid <= 1'b1;
                    tgt_req_write <= 1'b1;
                    tgt_req_poisoned <= 1'b1;
                    @(posedge clk_sys);
                    tgt_req_valid <= 1'b0;
                    tgt_req_poisoned <= 1'b0;
                end else begin
                    // Same value again, so only the error matters
                    cfg_wr_poisoned <= 1'b1;
                    wr_cmd(2'b11, pcase[i]);
                    cfg_wr_poisoned <= 1'b0;
                end
                repeat (12) @(posedge clk_sys);
                check("cap_err", 32'(cap_n - n0),
                    32'(pcase[i][6]));
                check("messages", 32'(msg_count - m0),
                    32'(pcase[i][6] & pcase[i][8]));
                if (pcase[i][8] && pcase[i][6]) begin
                    check("fatal", 32'(last_fatal), 32'(rnd[1]));
                end
                rd_exp(8'h04, stat(pcase[i][6] & pcase[i][8]));
                acc(1'b1, 8'h04, 4'h8, 32'h4000_0000);
            end
        end
        $display("error test done");
        test_done();
    end
endmodule

`default_nettype wire
